// [rtl/silc_pkg.sv]
// Package of register map, field layouts and blink timing for the status indicator block.
package silc_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam int         ADDR_W         = 4;
   localparam logic [3:0] OFS_STD_CTL    = 4'h0;
   localparam logic [3:0] OFS_MISC_CTL   = 4'h1;
   localparam logic [3:0] OFS_ADV_CTL    = 4'h2;
   localparam logic [3:0] OFS_BLINK_RATE = 4'h3;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [7:0] RST_STD_CTL    = 8'h03;
   localparam logic [7:0] RST_MISC_CTL   = 8'h01;
   localparam logic [7:0] RST_ADV_CTL    = 8'h00;
   localparam logic [7:0] RST_BLINK_RATE = 8'h70;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int BIT_COLOUR_SEL  = 0;
   localparam int BIT_STEADY      = 1;
   localparam int BIT_OPTION_SEL  = 0;
   localparam int BIT_CONFIG_LOCK = 7;

   // Advanced control register layout.
   typedef struct packed {
      logic [1:0] rsvd_hi;
      logic       topology;
      logic       polarity;
      logic [1:0] rsvd_lo;
      logic [1:0] power_mode;
   } silc_adv_ctl_t;

   // Blink rate register layout.
   typedef struct packed {
      logic       rsvd_hi;
      logic [2:0] green_rate;
      logic       rsvd_lo;
      logic [2:0] yellow_rate;
   } silc_blink_rate_t;

   // Power modes of the advanced option.
   localparam logic [1:0] PMODE_SW_ONLY   = 2'h0;
   localparam logic [1:0] PMODE_SUPPLY_YB = 2'h1;
   localparam logic [1:0] PMODE_SLEEP_OFF = 2'h2;
   localparam logic [1:0] PMODE_SUPPLY_OF = 2'h3;

   // Rate codes: off and on are static levels, 011 is the 1 Hz blink.
   localparam logic [2:0] RATE_OFF  = 3'h0;
   localparam logic [2:0] RATE_1HZ  = 3'h3;
   localparam logic [2:0] RATE_ON   = 3'h7;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_HZ  = 250_000_000;
   localparam int TICK_HZ = 32_768;
   // Blink period and on time per generator, in milliseconds.
   // Index 0..5 are rate codes 1..6, index 6 is the standard blink.
   localparam int NUM_GEN = 7;
   localparam int STD_GEN = 6;
   localparam int PERIOD_MS [NUM_GEN] = '{4000, 2000, 1000, 500, 333, 250, 1500};
   localparam int ON_MS     [NUM_GEN] = '{500, 500, 500, 250, 167, 125, 625};

endpackage : silc_pkg

// [rtl/silc_blink_gen.sv]
// Free-running blink generator counting standby ticks.
module silc_blink_gen #(
   parameter int PERIOD_TICKS = 32768,
   parameter int ON_TICKS     = 16384
) (
   input  wire logic clock,
   input  wire logic nrst,
   input  wire logic tick,
   output logic      wave_ff,
   output logic      wrap
);

   localparam int CNT_W = $clog2(PERIOD_TICKS);
   localparam logic [CNT_W-1:0] LAST = CNT_W'(PERIOD_TICKS - 1);
   localparam logic [CNT_W-1:0] ON_N = CNT_W'(ON_TICKS);

   // ****************************************************************
   // Parameter check
   // ****************************************************************
   if (PERIOD_TICKS < 2 || ON_TICKS < 1 || ON_TICKS >= PERIOD_TICKS) begin : g_bad
      $error("silc_blink_gen: on time must be inside the period.");
   end

   logic [CNT_W-1:0] cnt_ff;

   // A period ends on the tick that takes the counter back to zero.
   assign wrap = tick && (cnt_ff == LAST);

   // Phase counter, shared start point for all generators after reset.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         cnt_ff <= '0;
      end else if (wrap) begin
         cnt_ff <= '0;
      end else if (tick) begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end

   // On time sits at the start of each period. The level is taken from the
   // count after this edge, so it only moves on a tick and never runs ahead.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         wave_ff <= 1'b1;
      end else begin
         wave_ff <= (wrap ? '0 : (tick ? cnt_ff + 1'b1 : cnt_ff)) < ON_N;
      end
   end

endmodule // silc_blink_gen

// [rtl/silc_top.sv]
// Status indicator control: registers, option logic and open-drain pin drive.
//
// Behaviour
// R1: Option bit selects standard or advanced registers.
// R2: Standard option: deep sleep forces both pins low.
// R3: Colour select picks lit pin; other held low.
// R4: Steady bit: release pin, else 0.667 Hz blink.
// R5: Lock bit sets once, blocks all writes.
// R6: Topology bit: dual-colour LED or two LEDs.
// R7: Polarity bit sets on level; swaps dual colours.
// R8: Power mode 00 follows rate fields only.
// R9: Mode 01 supply off: yellow blinks 1 Hz.
// R10: Mode 10: both off in deep sleep.
// R11: Mode 11: both off while supply off.
// R12: Green rate field encoding off to on.
// R13: Yellow rate field uses same encoding.
// R14: Blink rate resets 0x70, reserved bits zero.
// R15: Dual-colour pin levels per polarity.
// R16: Two-LED polarity applied to both pins.
// R17: All timing from divided standby tick.
// R18: Unselected option offsets read zero, ignore writes.
// R19: Shared free-running timebase, change at boundary.
module silc_top #(
   parameter int TICK_DIV = silc_pkg::CLK_HZ / silc_pkg::TICK_HZ
) (
   input  wire logic                        clock,
   input  wire logic                        nrst,
   input  wire logic [silc_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic                        reg_wr_en,
   input  wire logic                        reg_rd_en,
   input  wire logic [7:0]                  reg_wdata,
   output logic      [7:0]                  reg_rdata_ff,
   output logic                             reg_rd_valid_ff,
   input  wire logic                        deep_sleep_n,
   input  wire logic                        main_supply_on,
   output logic                             config_lock,
   output logic                             green_indicator_pin_o,
   output logic                             green_indicator_pin_oe,
   output logic                             yellow_indicator_pin_o,
   output logic                             yellow_indicator_pin_oe
);

   // ****************************************************************
   // Parameter check
   // ****************************************************************
   localparam int DIV_W = $clog2(TICK_DIV);

   if (TICK_DIV < 2) begin : g_bad_div
      $error("silc_top: tick divider must be at least 2.");
   end

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic [7:0]                 std_ctl_ff;
   logic [7:0]                 misc_ctl_ff;
   silc_pkg::silc_adv_ctl_t    adv_ctl_ff;
   silc_pkg::silc_blink_rate_t rate_ff;
   logic [DIV_W-1:0]           div_ff;
   logic                       tick;
   logic [1:0]                 sleep_sync_ff;
   logic [1:0]                 supply_sync_ff;
   logic                       sleep_n;
   logic                       supply_on;
   logic                       option_std;
   logic                       wr_ok;
   logic [silc_pkg::NUM_GEN-1:0] gen_wave;
   logic [silc_pkg::NUM_GEN-1:0] gen_wrap;
   logic [2:0]                 green_req;
   logic [2:0]                 yellow_req;
   logic [2:0]                 green_act_ff;
   logic [2:0]                 yellow_act_ff;
   logic                       green_sw_on;
   logic                       yellow_sw_on;
   logic                       green_lit;
   logic                       yellow_lit;
   logic                       mode_off;
   logic                       green_rel;
   logic                       yellow_rel;
   logic                       green_drive_ff;
   logic                       yellow_drive_ff;
   logic [7:0]                 nxt_rdata;

   // ****************************************************************
   // Standby tick and blink generators
   // ****************************************************************

   // The core clock is divided to the standby rate so the blink
   // periods do not depend on the core clock frequency.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         div_ff <= '0;
      end else if (div_ff == DIV_W'(TICK_DIV - 1)) begin
         div_ff <= '0; // see R17
      end else begin
         div_ff <= div_ff + 1'b1;
      end
   end

   assign tick = (div_ff == DIV_W'(TICK_DIV - 1)); // see R17

   // One generator per rate, all started together so that equal
   // rates on both colours stay in phase.
   for (genvar gi = 0; gi < silc_pkg::NUM_GEN; gi++) begin : g_gen
      silc_blink_gen #(
         .PERIOD_TICKS ((silc_pkg::PERIOD_MS[gi] * silc_pkg::TICK_HZ + 500) / 1000),
         .ON_TICKS     ((silc_pkg::ON_MS[gi] * silc_pkg::TICK_HZ + 500) / 1000)
      ) u_gen (
         .clock   (clock),
         .nrst    (nrst),
         .tick    (tick),
         .wave_ff (gen_wave[gi]),
         .wrap    (gen_wrap[gi])
      ); // see R19
   end

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************

   // Sleep pin and supply detector come from outside this clock.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         sleep_sync_ff  <= 2'h3;
         supply_sync_ff <= 2'h3;
      end else begin
         sleep_sync_ff  <= {sleep_sync_ff[0], deep_sleep_n};
         supply_sync_ff <= {supply_sync_ff[0], main_supply_on};
      end
   end

   assign sleep_n   = sleep_sync_ff[1];
   assign supply_on = supply_sync_ff[1];

   // ****************************************************************
   // Register file
   // ****************************************************************
   assign option_std  = misc_ctl_ff[silc_pkg::BIT_OPTION_SEL];
   assign config_lock = misc_ctl_ff[silc_pkg::BIT_CONFIG_LOCK];
   assign wr_ok       = reg_wr_en && !config_lock; // see R5

   // Standard control; only the two low bits are stored.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         std_ctl_ff <= silc_pkg::RST_STD_CTL;
      end else if (wr_ok && option_std && reg_addr == silc_pkg::OFS_STD_CTL) begin
         std_ctl_ff <= {6'h00, reg_wdata[1:0]}; // see R1
      end
   end

   // Miscellaneous control: lock can only be set, never cleared by writes.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         misc_ctl_ff <= silc_pkg::RST_MISC_CTL;
      end else if (wr_ok && reg_addr == silc_pkg::OFS_MISC_CTL) begin
         misc_ctl_ff[silc_pkg::BIT_OPTION_SEL] <= reg_wdata[silc_pkg::BIT_OPTION_SEL];
         if (reg_wdata[silc_pkg::BIT_CONFIG_LOCK]) begin
            misc_ctl_ff[silc_pkg::BIT_CONFIG_LOCK] <= 1'b1; // see R5
         end
      end
   end

   // Advanced control; reserved bits never store.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         adv_ctl_ff <= silc_pkg::RST_ADV_CTL;
      end else if (wr_ok && !option_std && reg_addr == silc_pkg::OFS_ADV_CTL) begin
         adv_ctl_ff            <= silc_pkg::RST_ADV_CTL; // see R18
         adv_ctl_ff.topology   <= reg_wdata[5];
         adv_ctl_ff.polarity   <= reg_wdata[4];
         adv_ctl_ff.power_mode <= reg_wdata[1:0];
      end
   end

   // Blink rate; reserved bits 7 and 3 stay zero.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         rate_ff <= silc_pkg::RST_BLINK_RATE; // see R14
      end else if (wr_ok && !option_std && reg_addr == silc_pkg::OFS_BLINK_RATE) begin
         rate_ff             <= '0;
         rate_ff.green_rate  <= reg_wdata[6:4]; // see R12
         rate_ff.yellow_rate <= reg_wdata[2:0]; // see R13
      end
   end

   // Read mux; the hidden option's offsets return zero but keep contents.
   always_comb begin
      nxt_rdata = 8'h00;
      unique case (reg_addr)
         silc_pkg::OFS_STD_CTL:    nxt_rdata = option_std ? std_ctl_ff : 8'h00; // see R18
         silc_pkg::OFS_MISC_CTL:   nxt_rdata = misc_ctl_ff;
         silc_pkg::OFS_ADV_CTL:    nxt_rdata = option_std ? 8'h00 : adv_ctl_ff; // see R18
         silc_pkg::OFS_BLINK_RATE: nxt_rdata = option_std ? 8'h00 : rate_ff; // see R1
         default:                  nxt_rdata = 8'h00;
      endcase
   end

   // Read data is registered and valid one cycle after the strobe.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         reg_rdata_ff    <= 8'h00;
         reg_rd_valid_ff <= 1'b0;
      end else begin
         reg_rd_valid_ff <= reg_rd_en;
         if (reg_rd_en) begin
            reg_rdata_ff <= nxt_rdata;
         end
      end
   end

   // ****************************************************************
   // Advanced option: rate selection
   // ****************************************************************

   // In mode 01 with the supply off, yellow is forced to the 1 Hz rate.
   assign green_req  = rate_ff.green_rate;
   assign yellow_req = (adv_ctl_ff.power_mode == silc_pkg::PMODE_SUPPLY_YB && !supply_on) ?
                       silc_pkg::RATE_1HZ : rate_ff.yellow_rate; // see R9

   // A new rate is taken at the end of the running period so that a
   // change never produces a runt pulse; static codes switch at once.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         green_act_ff <= silc_pkg::RST_BLINK_RATE[6:4];
      end else if (green_act_ff == silc_pkg::RATE_OFF || green_act_ff == silc_pkg::RATE_ON ||
                   gen_wrap[green_act_ff - 3'h1]) begin
         green_act_ff <= green_req; // see R19
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         yellow_act_ff <= silc_pkg::RST_BLINK_RATE[2:0];
      end else if (yellow_act_ff == silc_pkg::RATE_OFF || yellow_act_ff == silc_pkg::RATE_ON ||
                   gen_wrap[yellow_act_ff - 3'h1]) begin
         yellow_act_ff <= yellow_req; // see R19
      end
   end

   // Rate code to on state: 000 off, 111 on, others a generator.
   always_comb begin
      green_sw_on  = 1'b0;
      yellow_sw_on = 1'b0;
      unique case (green_act_ff)
         silc_pkg::RATE_OFF: green_sw_on = 1'b0;
         silc_pkg::RATE_ON:  green_sw_on = 1'b1;
         default:            green_sw_on = gen_wave[green_act_ff - 3'h1]; // see R12
      endcase
      unique case (yellow_act_ff)
         silc_pkg::RATE_OFF: yellow_sw_on = 1'b0;
         silc_pkg::RATE_ON:  yellow_sw_on = 1'b1;
         default:            yellow_sw_on = gen_wave[yellow_act_ff - 3'h1]; // see R13
      endcase
   end

   // ****************************************************************
   // Advanced option: power-state gating
   // ****************************************************************

   // Mode 00 and 01 never blank; 10 blanks in deep sleep; 11 blanks
   // while the main supply is off.
   always_comb begin
      mode_off = 1'b0;
      unique case (adv_ctl_ff.power_mode)
         silc_pkg::PMODE_SW_ONLY:   mode_off = 1'b0; // see R8
         silc_pkg::PMODE_SUPPLY_YB: mode_off = 1'b0; // see R9
         silc_pkg::PMODE_SLEEP_OFF: mode_off = !sleep_n; // see R10
         silc_pkg::PMODE_SUPPLY_OF: mode_off = !supply_on; // see R11
      endcase
   end

   assign green_lit  = green_sw_on && !mode_off;
   assign yellow_lit = yellow_sw_on && !mode_off;

   // ****************************************************************
   // Pin levels
   // ****************************************************************

   // Release means the open-drain output floats; otherwise it pulls low.
   // A dual-colour LED cannot show both colours, so green wins when
   // both are lit, and both pins pull low when neither is.
   always_comb begin
      green_rel  = 1'b0;
      yellow_rel = 1'b0;
      if (option_std) begin
         green_rel  = sleep_n && std_ctl_ff[silc_pkg::BIT_COLOUR_SEL] &&
                      (std_ctl_ff[silc_pkg::BIT_STEADY] || gen_wave[silc_pkg::STD_GEN]); // see R2 R4
         yellow_rel = sleep_n && !std_ctl_ff[silc_pkg::BIT_COLOUR_SEL] &&
                      (std_ctl_ff[silc_pkg::BIT_STEADY] || gen_wave[silc_pkg::STD_GEN]); // see R3
      end else if (adv_ctl_ff.topology) begin // see R6
         green_rel  = green_lit ^ adv_ctl_ff.polarity; // see R16
         yellow_rel = yellow_lit ^ adv_ctl_ff.polarity; // see R16
      end else begin
         green_rel  = adv_ctl_ff.polarity ? (yellow_lit && !green_lit) : green_lit; // see R15
         yellow_rel = adv_ctl_ff.polarity ? green_lit : (yellow_lit && !green_lit); // see R7
      end
   end

   // Output enables are registered to keep the pins glitch free.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         green_drive_ff  <= 1'b1;
         yellow_drive_ff <= 1'b1;
      end else begin
         green_drive_ff  <= !green_rel; // see R4
         yellow_drive_ff <= !yellow_rel; // see R6
      end
   end

   // Open-drain: the data level is always low, only the enable moves.
   assign green_indicator_pin_o   = 1'b0;
   assign yellow_indicator_pin_o  = 1'b0;
   assign green_indicator_pin_oe  = green_drive_ff;
   assign yellow_indicator_pin_oe = yellow_drive_ff;

endmodule // silc_top

// [dv/silc_led_model.sv]
// Behavioural model of the LEDs hanging on the two open-drain indicator pins.
module silc_led_model (
   input  wire logic green_pin_o,
   input  wire logic green_pin_oe,
   input  wire logic yellow_pin_o,
   input  wire logic yellow_pin_oe,
   output logic      green_level,
   output logic      yellow_level
);
   timeunit 1ns;
   timeprecision 1ps;
   // A released pin is pulled up through its LED, so it never shows the last driven value.
   assign green_level  = green_pin_oe ? green_pin_o : 1'b1;
   assign yellow_level = yellow_pin_oe ? yellow_pin_o : 1'b1;
endmodule // silc_led_model

// [dv/silc_top_monitor.sv]
// Checker of register port and pin drive relations of the status indicator block.
module silc_top_monitor #(
   parameter int TICK_DIV = 2
) (
   input wire logic                        clock,
   input wire logic                        nrst,
   input wire logic [silc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic                        reg_wr_en,
   input wire logic                        reg_rd_en,
   input wire logic [7:0]                  reg_wdata,
   input wire logic [7:0]                  reg_rdata_ff,
   input wire logic                        reg_rd_valid_ff,
   input wire logic                        deep_sleep_n,
   input wire logic                        main_supply_on,
   input wire logic                        config_lock,
   input wire logic                        green_indicator_pin_o,
   input wire logic                        green_indicator_pin_oe,
   input wire logic                        yellow_indicator_pin_o,
   input wire logic                        yellow_indicator_pin_oe
);
   // ********
   // Helpers
   // ********
   logic opt_ff;
   logic lock_req;
   logic misc_wr;

   // Writes to the misc register; a one in the lock bit is a request to lock.
   assign misc_wr  = reg_wr_en && reg_addr == silc_pkg::OFS_MISC_CTL;
   assign lock_req = misc_wr && reg_wdata[silc_pkg::BIT_CONFIG_LOCK];

   // Shadow of the option bit; the lock freezes it just as it freezes the block's copy.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         opt_ff <= 1'b1;
      end else if (misc_wr && !config_lock) begin
         opt_ff <= reg_wdata[silc_pkg::BIT_OPTION_SEL];
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);

   // ********
   // Checks
   // ********
   a_read_answer: assert property (reg_rd_en |=> reg_rd_valid_ff)
      else $error("read not answered in the next cycle");
   a_valid_cause: assert property (reg_rd_valid_ff |-> $past(reg_rd_en))
      else $error("read valid without a read");
   a_lock_cause: assert property ($rose(config_lock) |-> $past(lock_req))
      else $error("lock set without a write of one");
   a_lock_hold: assert property (config_lock |=> config_lock)
      else $error("lock cleared without reset");
   a_unmapped_zero: assert property (reg_rd_en && reg_addr > 4'h3 |=> reg_rdata_ff == 8'h00)
      else $error("unmapped offset read nonzero");
   a_rate_rsvd: assert property (reg_rd_en && reg_addr == 4'h3 |=> !reg_rdata_ff[7] && !reg_rdata_ff[3])
      else $error("reserved rate bits read nonzero");
   a_std_hidden: assert property (reg_rd_en && reg_addr == 4'h0 && !opt_ff |=> reg_rdata_ff == 8'h00)
      else $error("hidden standard register read nonzero");
   a_sleep_dark: assert property (opt_ff && !deep_sleep_n [*4] |=> green_indicator_pin_oe && yellow_indicator_pin_oe)
      else $error("pins not low in deep sleep");
endmodule // silc_top_monitor

bind silc_top silc_top_monitor #(.TICK_DIV(TICK_DIV)) mon_u (
   .clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
   .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .reg_rd_valid_ff(reg_rd_valid_ff),
   .deep_sleep_n(deep_sleep_n), .main_supply_on(main_supply_on), .config_lock(config_lock),
   .green_indicator_pin_o(green_indicator_pin_o), .green_indicator_pin_oe(green_indicator_pin_oe),
   .yellow_indicator_pin_o(yellow_indicator_pin_o), .yellow_indicator_pin_oe(yellow_indicator_pin_oe)
);

// [dv/silc_top_tb.sv]
// Self-checking testbench of the status indicator block with an LED model on its pins.
module silc_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; $display("[ERR] t=%0t %h %h", $time, g, e); end end

   // ********
   // Signals
   // ********
   logic                        clock;
   logic                        nrst;
   logic [silc_pkg::ADDR_W-1:0] reg_addr;
   logic                        reg_wr_en;
   logic                        reg_rd_en;
   logic [7:0]                  reg_wdata;
   logic [7:0]                  reg_rdata_ff;
   logic                        reg_rd_valid_ff;
   logic                        deep_sleep_n;
   logic                        main_supply_on;
   logic                        config_lock;
   logic                        green_o, green_oe, yellow_o, yellow_oe, green_level, yellow_level;
   logic [7:0]                  exp_q[$];
   logic [7:0]                  exp_v, d, v;
   logic [1:0]                  exp2;
   int                          fails, comparisons, cycles, gh, yh, gr, eq;
   localparam logic [7:0] RATES [4] = '{8'h77, 8'h00, 8'h70, 8'h07};
   // Each entry holds power mode, sleep level, supply level and whether the pins follow.
   localparam logic [4:0] PMODES [6] = '{5'b00001, 5'b10010, 5'b10101, 5'b11100, 5'b11011, 5'b01111};

   silc_top #(.TICK_DIV(2)) dut_u (
      .clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
      .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .reg_rd_valid_ff(reg_rd_valid_ff),
      .deep_sleep_n(deep_sleep_n), .main_supply_on(main_supply_on), .config_lock(config_lock),
      .green_indicator_pin_o(green_o), .green_indicator_pin_oe(green_oe),
      .yellow_indicator_pin_o(yellow_o), .yellow_indicator_pin_oe(yellow_oe)
   );
   silc_led_model led_u (
      .green_pin_o(green_o), .green_pin_oe(green_oe), .yellow_pin_o(yellow_o), .yellow_pin_oe(yellow_oe),
      .green_level(green_level), .yellow_level(yellow_level)
   );

   // Clock and a cycle ceiling well above the longest blink windows used below.
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 90000) begin
         fails++;
         conclude();
      end
   end

   // Read data is compared on the falling edge, where it has settled.
   always @(negedge clock) begin
      if (reg_rd_valid_ff === 1'b1) begin
         exp_v = exp_q.pop_front();
         `CHK(reg_rdata_ff, exp_v)
      end
   end

   // ********
   // Tasks
   // ********
   task automatic wr(input logic [silc_pkg::ADDR_W-1:0] a, input logic [7:0] val);
      @(posedge clock);
      #1;
      reg_addr = a;
      reg_wdata = val;
      reg_wr_en = 1'b1;
      @(posedge clock);
      #1;
      reg_wr_en = 1'b0;
   endtask
   task automatic rd(input logic [silc_pkg::ADDR_W-1:0] a, input logic [7:0] e);
      @(posedge clock);
      #1;
      reg_addr = a;
      reg_rd_en = 1'b1;
      exp_q.push_back(e);
      @(posedge clock);
      #1;
      reg_rd_en = 1'b0;
   endtask
   // Four cycles cover the register stage and the two synchroniser stages.
   task automatic pins(input logic g, input logic y);
      repeat (4) @(posedge clock);
      #1;
      `CHK({green_level, yellow_level}, {g, y})
   endtask
   // Counts high cycles, green rises and cycles where both pins agree.
   task automatic sample(input int n);
      logic gp;
      repeat (2) @(posedge clock);
      #1;
      gp = green_level;
      gh = 0;
      yh = 0;
      gr = 0;
      eq = 0;
      repeat (n) begin
         @(posedge clock);
         #1;
         gh += int'(green_level === 1'b1);
         yh += int'(yellow_level === 1'b1);
         gr += int'(green_level === 1'b1 && gp === 1'b0);
         eq += int'(green_level === yellow_level);
         gp = green_level;
      end
   endtask
   task automatic conclude();
      $display("comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ********
   // Sequence
   // ********
   initial begin
      {nrst, reg_addr, reg_wdata, reg_wr_en, reg_rd_en} = '0;
      deep_sleep_n = 1'b1;
      main_supply_on = 1'b1;
      d = 8'($urandom(67722));
      repeat (5) @(posedge clock);
      #1;
      nrst = 1'b1;
      rd(4'h0, 8'h03);
      rd(4'h1, 8'h01);
      rd(4'h2, 8'h00);
      rd(4'hc, 8'h00);
      pins(1'b1, 1'b0);
      $display("test reset done");
      wr(4'h0, 8'h02);
      pins(1'b0, 1'b1);
      deep_sleep_n = 1'b0;
      pins(1'b0, 1'b0);
      deep_sleep_n = 1'b1;
      wr(4'h0, 8'h01);
      pins(1'b1, 1'b0);
      $display("test standard done");
      // The write to offset 0 in the advanced option must be dropped.
      wr(4'h1, 8'h00);
      wr(4'h0, 8'h00);
      rd(4'h0, 8'h00);
      rd(4'h3, 8'h70);
      d = 8'($urandom());
      wr(4'h2, d);
      rd(4'h2, d & 8'h33);
      d = 8'($urandom());
      v = (d & 8'h88) | (d[4] ? 8'h70 : 8'h00) | (d[0] ? 8'h07 : 8'h00);
      wr(4'h3, v);
      rd(4'h3, v & 8'h77);
      wr(4'h1, 8'h01);
      rd(4'h3, 8'h00);
      rd(4'h0, 8'h01);
      wr(4'h1, 8'h00);
      $display("test options done");
      foreach (RATES[r]) begin
         for (int c = 0; c < 4; c++) begin
            wr(4'h3, RATES[r]);
            wr(4'h2, {2'b00, 2'(c), 4'h0});
            if (c[1]) exp2 = {RATES[r][6] ^ c[0], RATES[r][2] ^ c[0]};
            else if (RATES[r][6] | RATES[r][2]) exp2 = (RATES[r][6] ^ c[0]) ? 2'b10 : 2'b01;
            else exp2 = 2'b00;
            pins(exp2[1], exp2[0]);
         end
      end
      $display("test topology done");
      // Both colours steady on, so following pins read high on both.
      wr(4'h3, 8'h77);
      foreach (PMODES[i]) begin
         wr(4'h2, {6'h08, PMODES[i][4:3]});
         deep_sleep_n = PMODES[i][2];
         main_supply_on = PMODES[i][1];
         pins(PMODES[i][0], PMODES[i][0]);
      end
      deep_sleep_n = 1'b1;
      main_supply_on = 1'b1;
      $display("test power modes done");
      wr(4'h2, 8'h20);
      wr(4'h3, 8'h55);
      sample(21824);
      `CHK(gh, 10944)
      `CHK(yh, 10944)
      `CHK(gr, 1)
      `CHK(eq, 21824)
      // The green rate change waits for the end of the running 3 Hz period.
      wr(4'h3, 8'h77);
      wr(4'h2, 8'h21);
      main_supply_on = 1'b0;
      repeat (21840) @(posedge clock);
      sample(33000);
      `CHK(gh, 33000)
      `CHK(yh > 0 && yh < 33000, 1'b1)
      main_supply_on = 1'b1;
      $display("test blink done");
      wr(4'h1, 8'h80);
      `CHK(config_lock, 1'b1)
      wr(4'h3, 8'h00);
      rd(4'h3, 8'h77);
      wr(4'h1, 8'h01);
      rd(4'h1, 8'h80);
      nrst = 1'b0;
      repeat (5) @(posedge clock);
      #1;
      nrst = 1'b1;
      `CHK(config_lock, 1'b0)
      rd(4'h1, 8'h01);
      rd(4'h0, 8'h03);
      repeat (4) @(posedge clock);
      `CHK(exp_q.size(), 0)
      $display("test lock done");
      conclude();
   end
endmodule // silc_top_tb
